// *** logic/pcgs_pkg.sv ***
// register map, field layout and carriers of the clock generator block
package pcgs_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned LOCK_WAIT_US  = 1000;
  localparam int unsigned LOCK_WAIT_CYC = LOCK_WAIT_US * 1000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_PLL_REF  = 8'h00;
  localparam logic [7:0] OFF_PLL_FB   = 8'h04;
  localparam logic [7:0] OFF_PMODE    = 8'h08;
  localparam logic [7:0] OFF_CDIV     = 8'h0C;
  localparam logic [7:0] OFF_PBT      = 8'h10;
  localparam logic [7:0] OFF_PROTECT  = 8'h14;
  localparam logic [7:0] OFF_KEY      = 8'h18;
  localparam logic [7:0] OFF_CTRL     = 8'h1C;
  localparam logic [7:0] OFF_STATUS   = 8'h20;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_PLL_REF = 8'h00;
  localparam logic [7:0]  RST_PLL_FB  = 8'h00;
  localparam logic [7:0]  RST_PMODE   = 8'h00;
  localparam logic [7:0]  RST_CDIV    = 8'h9F;
  localparam logic [15:0] RST_PBT     = 16'h0405;
  localparam logic [15:0] RST_RELOAD  = 16'h3E80;
  localparam logic [7:0]  PROTECT_KEY = 8'hAA;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SRC_SEL_BIT    = 7;
  localparam int PCD_LSB        = 4;
  localparam int CCD_LSB        = 2;
  localparam int BCD_LSB        = 0;
  localparam int PSRC_DIV_LSB   = 5;
  localparam int SCV_LSB        = 5;
  localparam int MCV_LSB        = 0;
  localparam int RCV_LSB        = 0;
  localparam int PWR_LSB        = 0;
  localparam int PRD_LSB        = 8;
  localparam int UNLOCK_CLK_BIT = 0;
  localparam int UNLOCK_PLL_BIT = 2;
  localparam int CTRL_START_BIT = 16;
  localparam int CTRL_MODE_BIT  = 17;

  // ---------------------------------------------------------------
  // synthesizer constants
  // ---------------------------------------------------------------
  localparam logic [7:0]  MAIN_MULT   = 8'h05;
  localparam logic [15:0] SELF_INC    = 16'h0001;
  localparam logic [15:0] SELF_PERIOD = 16'h0004;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pcgs_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } pcgs_apb_rsp_type;

  typedef struct packed {
    logic pll;
    logic base;
    logic cpu;
    logic bus;
    logic periph;
  } pcgs_ticks_type;

  function automatic logic [4:0] base_ratio(input logic [1:0] code);
    case (code)
      2'h0:    base_ratio = 5'h08;
      2'h1:    base_ratio = 5'h06;
      2'h2:    base_ratio = 5'h04;
      default: base_ratio = 5'h02;
    endcase
  endfunction

  function automatic logic [4:0] cpu_ratio(input logic [1:0] code);
    case (code)
      2'h0:    cpu_ratio = 5'h08;
      2'h1:    cpu_ratio = 5'h04;
      2'h2:    cpu_ratio = 5'h02;
      default: cpu_ratio = 5'h01;
    endcase
  endfunction

  // code 0 is illegal; it is run as divide by 2 to stay harmless
  function automatic logic [4:0] bus_ratio(input logic [1:0] code);
    case (code)
      2'h2:    bus_ratio = 5'h03;
      2'h3:    bus_ratio = 5'h04;
      default: bus_ratio = 5'h02;
    endcase
  endfunction

  function automatic logic [4:0] periph_ratio(input logic [1:0] code);
    case (code)
      2'h0:    periph_ratio = 5'h01;
      2'h1:    periph_ratio = 5'h02;
      2'h2:    periph_ratio = 5'h04;
      default: periph_ratio = 5'h08;
    endcase
  endfunction

endpackage

// *** logic/pcgs_tick_div.sv ***
// tick divider: one output tick for every ratio input ticks
`timescale 1ns/10ps
`default_nettype none
module pcgs_tick_div
  import pcgs_pkg::*;
#(
  parameter int RW = 5
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          tick_in,
  input  wire logic [RW-1:0] ratio,
  output logic               tick_out
);

  typedef struct packed {
    logic [RW-1:0] cnt;
    logic          out;
  } pcgs_div_state_type;

  pcgs_div_state_type st_q;
  pcgs_div_state_type st_d;

  always_comb begin
    st_d     = st_q;
    st_d.out = 1'b0;
    if (tick_in) begin
      // a ratio lowered below the count fires at once and restarts
      if (RW'(st_q.cnt + 1'b1) >= ratio) begin
        st_d.cnt = '0;
        st_d.out = 1'b1;
      end else begin
        st_d.cnt = RW'(st_q.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick_out = st_q.out;

endmodule // pcgs_tick_div
`default_nettype wire

// *** logic/pcgs_lock_timer.sv ***
// lock wait timer, run in either mode, counting undivided main clock ticks
`timescale 1ns/10ps
`default_nettype none
module pcgs_lock_timer
  import pcgs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        main_tick,
  input  wire logic        start,
  input  wire logic [15:0] reload,
  output logic             running,
  output logic             done,
  output logic [15:0]      count
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        run;
    logic        done;
  } pcgs_tmr_state_type;

  pcgs_tmr_state_type st_q;
  pcgs_tmr_state_type st_d;

  always_comb begin
    st_d = st_q;
    if (start) begin
      st_d.cnt  = reload;
      st_d.run  = (reload != 16'h0000);
      st_d.done = (reload == 16'h0000);
    end else if (st_q.run && main_tick) begin
      if (st_q.cnt == 16'h0001) begin
        st_d.cnt  = 16'h0000;
        st_d.run  = 1'b0;
        st_d.done = 1'b1;
      end else begin
        st_d.cnt = 16'(st_q.cnt - 16'h0001);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign running = st_q.run;
  assign done    = st_q.done;
  assign count   = st_q.cnt;

endmodule // pcgs_lock_timer
`default_nettype wire

// *** logic/pcgs_top.sv ***
// clock generator: pll synthesizer, clock dividers, protection, apb slave
`timescale 1ns/10ps
`default_nettype none
module pcgs_top
  import pcgs_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = LOCK_WAIT_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire pcgs_apb_req_type  apb_req,
  output pcgs_apb_rsp_type       apb_rsp,
  input  wire logic              main_osc_input,
  output pcgs_ticks_type         clk_ticks,
  output logic [4:0]             bus_write_timing,
  output logic [4:0]             bus_read_timing,
  output logic                   pll_locked
);

  localparam int LW = $clog2(LOCK_CYCLES + 1);
  localparam logic [LW-1:0] LOCK_LOAD = LW'(LOCK_CYCLES);

  typedef struct packed {
    logic          pready;
    logic [31:0]   prdata;
    logic          pslverr;
    logic [7:0]    pll_ref;
    logic [7:0]    pll_fb;
    logic [7:0]    pmode;
    logic [7:0]    cdiv;
    logic [15:0]   pbt;
    logic [7:0]    prot;
    logic [7:0]    key;
    logic [15:0]   reload;
    logic          mode;
    logic          tmr_start;
    logic          main_prev;
    logic          main_tick;
    logic [15:0]   per_cnt;
    logic [15:0]   period;
    logic [15:0]   acc;
    logic          pll_tick;
    logic [LW-1:0] lock_cnt;
    logic          locked;
  } pcgs_top_state_type;

  pcgs_top_state_type st_q;
  pcgs_top_state_type st_d;

  logic        ref_tick;
  logic        base_tick;
  logic        cpu_tick;
  logic        bus_tick;
  logic        periph_tick;
  logic        tmr_running;
  logic        tmr_done;
  logic [15:0] tmr_count;

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  logic [2:0] scv;
  logic [4:0] mcv;
  logic [3:0] rcv;
  logic [7:0] mult;
  logic [4:0] ref_ratio;
  logic       base_src_tick;

  assign scv = st_q.pll_fb[SCV_LSB +: 3];
  assign mcv = st_q.pll_fb[MCV_LSB +: 5];
  assign rcv = st_q.pll_ref[RCV_LSB +: 4];
  // m = 5 (field + 1) + a
  assign mult = 8'(MAIN_MULT * ({3'h0, mcv} + 8'h01))
              + {5'h00, scv};
  assign ref_ratio = {1'b0, rcv} + 5'h01;
  // main oscillator or pll clock ahead of the base divider
  assign base_src_tick = st_q.cdiv[SRC_SEL_BIT] ? st_q.main_tick
                                                : st_q.pll_tick;

  // ---------------------------------------------------------------
  // dividers
  // ---------------------------------------------------------------
  pcgs_tick_div #(.RW(5)) u_ref_div (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .tick_in  (st_q.main_tick),
    .ratio    (ref_ratio),
    .tick_out (ref_tick)
  );
  pcgs_tick_div #(.RW(5)) u_base_div (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .tick_in  (base_src_tick),
    .ratio    (base_ratio(st_q.cdiv[BCD_LSB +: 2])),
    .tick_out (base_tick)
  );
  pcgs_tick_div #(.RW(5)) u_cpu_div (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .tick_in  (base_tick),
    .ratio    (cpu_ratio(st_q.cdiv[CCD_LSB +: 2])),
    .tick_out (cpu_tick)
  );
  pcgs_tick_div #(.RW(5)) u_bus_div (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .tick_in  (base_tick),
    .ratio    (bus_ratio(st_q.cdiv[PCD_LSB +: 2])),
    .tick_out (bus_tick)
  );
  pcgs_tick_div #(.RW(5)) u_periph_div (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .tick_in  (st_q.pll_tick),
    .ratio    (periph_ratio(st_q.pmode[PSRC_DIV_LSB +: 2])),
    .tick_out (periph_tick)
  );
  // counts the raw main clock, no divider in front
  pcgs_lock_timer u_lock_timer (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .main_tick (st_q.main_tick),
    .start     (st_q.tmr_start),
    .reload    (st_q.reload),
    .running   (tmr_running),
    .done      (tmr_done),
    .count     (tmr_count)
  );

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic        acc_phase;
  logic        wr_done;
  logic        hit;
  logic [31:0] rd_data;

  assign acc_phase = apb_req.psel && apb_req.penable;
  assign wr_done   = acc_phase && apb_req.pwrite && st_q.pready;

  always_comb begin
    hit     = 1'b1;
    rd_data = 32'h0000_0000;
    case (apb_req.paddr)
      OFF_PLL_REF: rd_data = {24'h000000, st_q.pll_ref};
      OFF_PLL_FB:  rd_data = {24'h000000, st_q.pll_fb};
      OFF_PMODE:   rd_data = {24'h000000, st_q.pmode};
      OFF_CDIV:    rd_data = {24'h000000, st_q.cdiv};
      OFF_PBT:     rd_data = {16'h0000, st_q.pbt};
      OFF_PROTECT: rd_data = {24'h000000, st_q.prot};
      OFF_KEY:     rd_data = {24'h000000, st_q.key};
      OFF_CTRL:    rd_data = {14'h0000, st_q.mode, 1'b0, st_q.reload};
      OFF_STATUS:  rd_data = {tmr_count, 12'h000, tmr_running, tmr_done,
                              st_q.locked, st_q.mode};
      default:     hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [15:0] inc;
  logic [15:0] per;
  logic [16:0] sum;
  logic [16:0] rem;

  always_comb begin
    st_d           = st_q;
    st_d.tmr_start = 1'b0;
    st_d.pll_tick  = 1'b0;
    st_d.main_prev = main_osc_input;
    st_d.main_tick = main_osc_input && !st_q.main_prev;
    // reference period, measured in ref_clk cycles
    if (ref_tick) begin
      st_d.period  = 16'(st_q.per_cnt + 16'h0001);
      st_d.per_cnt = 16'h0000;
    end else if (st_q.per_cnt != 16'hFFFF) begin
      st_d.per_cnt = 16'(st_q.per_cnt + 16'h0001);
    end
    // synthesizer: m output ticks per reference period
    if (st_q.mode) begin
      inc = {8'h00, mult};
      per = st_q.period;
    end else begin
      inc = SELF_INC;
      per = SELF_PERIOD;
    end
    sum = {1'b0, st_q.acc} + {1'b0, inc};
    rem = sum - {1'b0, per};
    if (per == 16'h0000) begin
      st_d.acc = 16'h0000;
    end else if (sum >= {1'b0, per}) begin
      st_d.pll_tick = 1'b1;
      // a rate above ref_clk is clipped rather than allowed to wrap
      st_d.acc = (rem >= {1'b0, per}) ? 16'h0000 : 16'(rem);
    end else begin
      st_d.acc = 16'(sum);
    end
    if (st_q.lock_cnt != '0) begin
      st_d.lock_cnt = LW'(st_q.lock_cnt - 1'b1);
    end
    // apb: one wait state, answer registered
    st_d.pready = acc_phase && !st_q.pready;
    if (acc_phase && !st_q.pready) begin
      st_d.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_data;
      st_d.pslverr = !hit;
    end
    if (wr_done) begin
      // any write other than to the protect register drops pll access
      if (apb_req.paddr != OFF_PROTECT) begin
        st_d.prot[UNLOCK_PLL_BIT] = 1'b0;
      end
      case (apb_req.paddr)
        OFF_PLL_REF: begin
          if (st_q.prot[UNLOCK_PLL_BIT]) begin
            st_d.pll_ref  = apb_req.pwdata[7:0];
            st_d.lock_cnt = LOCK_LOAD;
          end
        end
        OFF_PLL_FB: begin
          if (st_q.prot[UNLOCK_PLL_BIT]) begin
            st_d.pll_fb   = apb_req.pwdata[7:0];
            st_d.lock_cnt = LOCK_LOAD;
          end
        end
        OFF_PMODE: begin
          if (st_q.prot[UNLOCK_CLK_BIT]) begin
            st_d.pmode = apb_req.pwdata[7:0];
          end
        end
        OFF_CDIV: begin
          if (st_q.key == PROTECT_KEY) begin
            st_d.cdiv = apb_req.pwdata[7:0];
          end
        end
        OFF_PBT: begin
          if (st_q.key == PROTECT_KEY) begin
            st_d.pbt = apb_req.pwdata[15:0];
          end
        end
        OFF_PROTECT: st_d.prot = apb_req.pwdata[7:0];
        OFF_KEY:     st_d.key  = apb_req.pwdata[7:0];
        OFF_CTRL: begin
          st_d.reload    = apb_req.pwdata[15:0];
          st_d.tmr_start = apb_req.pwdata[CTRL_START_BIT];
          if (st_q.prot[UNLOCK_CLK_BIT]) begin
            if (st_q.mode != apb_req.pwdata[CTRL_MODE_BIT]) begin
              st_d.lock_cnt = LOCK_LOAD;
              st_d.acc      = 16'h0000;
            end
            st_d.mode = apb_req.pwdata[CTRL_MODE_BIT];
          end
        end
        default: ;
      endcase
    end
    st_d.locked = (st_d.lock_cnt == '0);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q         <= '0;
      st_q.pll_ref <= RST_PLL_REF;
      st_q.pll_fb  <= RST_PLL_FB;
      st_q.pmode   <= RST_PMODE;
      st_q.cdiv    <= RST_CDIV;
      st_q.pbt     <= RST_PBT;
      st_q.reload  <= RST_RELOAD;
      st_q.locked  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign apb_rsp.pready   = st_q.pready;
  assign apb_rsp.prdata   = st_q.prdata;
  assign apb_rsp.pslverr  = st_q.pslverr;
  assign clk_ticks.pll    = st_q.pll_tick;
  assign clk_ticks.base   = base_tick;
  assign clk_ticks.cpu    = cpu_tick;
  assign clk_ticks.bus    = bus_tick;
  assign clk_ticks.periph = periph_tick;
  assign bus_write_timing = st_q.pbt[PWR_LSB +: 5];
  assign bus_read_timing  = st_q.pbt[PRD_LSB +: 5];
  assign pll_locked       = st_q.locked;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  apb_wait_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (acc_phase && !apb_rsp.pready) |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("apb answer not after exactly one wait state");
  unlock_drop_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wr_done && apb_req.paddr != OFF_PROTECT)
      |=> !st_q.prot[UNLOCK_PLL_BIT])
    else $error("pll write unlock survived a later write");
  key_guard_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wr_done && apb_req.paddr == OFF_CDIV && st_q.key != PROTECT_KEY)
      |=> $stable(st_q.cdiv))
    else $error("clock divider register written without key");
  pll_guard_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wr_done && apb_req.paddr == OFF_PLL_FB
      && !st_q.prot[UNLOCK_PLL_BIT]) |=> $stable(st_q.pll_fb))
    else $error("feedback register written while locked out");
  self_osc_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (st_q.pll_tick && !st_q.mode && !$past(st_q.mode))
      |=> (!st_q.pll_tick || st_q.mode)[*3]
          ##1 (st_q.pll_tick || st_q.mode))
    else $error("self oscillation period is not four cycles");
  relock_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (wr_done && apb_req.paddr == OFF_PLL_REF
      && st_q.prot[UNLOCK_PLL_BIT]) |=> !pll_locked [*2])
    else $error("lock indication kept across a pll change");
  cpu_pass_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (base_tick && st_q.cdiv[CCD_LSB +: 2] == 2'h3
      && $stable(st_q.cdiv)) |=> cpu_tick)
    else $error("undivided cpu clock missed a base tick");
  base_half_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (base_tick && st_q.cdiv[BCD_LSB +: 2] == 2'h3 && $stable(st_q.cdiv))
      |-> !$past(base_tick))
    else $error("base clock at code 11 ran undivided");
  timer_start_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (st_q.tmr_start && st_q.reload != 16'h0000)
      |=> tmr_running && !tmr_done && tmr_count == $past(st_q.reload))
    else $error("lock wait timer did not load and run");

endmodule // pcgs_top
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the clock generator block
`timescale 1ns/10ps
`default_nettype none
module tb_top import pcgs_pkg::*;;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic             ref_clk = 1'b0;
  logic             rst = 1'b1;
  logic             main_osc_input = 1'b0;
  pcgs_apb_req_type apb_req = '0;
  pcgs_apb_rsp_type apb_rsp;
  pcgs_ticks_type   clk_ticks;
  logic [4:0]       bus_write_timing;
  logic [4:0]       bus_read_timing;
  logic             pll_locked;
  logic [31:0]      rd;
  logic             err;
  int               mismatches = 0;
  int               total_checks = 0;
  int               cyc = 0;
  int               tc[5];
  localparam int    LOCK_SIM = 20;

  pcgs_top #(.LOCK_CYCLES(LOCK_SIM)) uut (
    .ref_clk(ref_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .main_osc_input(main_osc_input), .clk_ticks(clk_ticks),
    .bus_write_timing(bus_write_timing), .bus_read_timing(bus_read_timing),
    .pll_locked(pll_locked));

  always #2.5 ref_clk = ~ref_clk;

  // 8 MHz main clock: 25 cycles, a tabulated reference choice
  always begin
    repeat (13) @(posedge ref_clk);
    main_osc_input <= 1'b1;
    repeat (12) @(posedge ref_clk);
    main_osc_input <= 1'b0;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_rate(input int g, input int e, input int tol);
    total_checks++;
    if (g < e - tol || g > e + tol) begin
      mismatches++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // entered just after a rising edge; holds until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    // no own limit: the cycle ceiling ends a hang
    do begin
      @(posedge ref_clk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic count(input int w);
    tc = '{default: 0};
    repeat (w) begin
      @(posedge ref_clk);
      tc[0] += clk_ticks.pll;
      tc[1] += clk_ticks.base;
      tc[2] += clk_ticks.cpu;
      tc[3] += clk_ticks.bus;
      tc[4] += clk_ticks.periph;
    end
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  task automatic t_reset;
    rchk(OFF_CDIV, 32'h0000009F);
    rchk(OFF_PBT, 32'h00000405);
    rchk(OFF_PLL_FB, 32'h00000000);
    chk({22'h0, bus_read_timing, bus_write_timing}, 32'h00000085);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h00000001);
    count(400);
    chk_rate(tc[0], 100, 1);
    $display("test reset done");
  endtask

  task automatic t_guard;
    wr(OFF_CDIV, 32'h0000001F);
    rchk(OFF_CDIV, 32'h0000009F);
    wr(OFF_PLL_FB, 32'h00000004);
    rchk(OFF_PLL_FB, 32'h00000000);
    wr(OFF_PMODE, 32'h00000040);
    rchk(OFF_PMODE, 32'h00000000);
    wr(OFF_KEY, 32'h000000AA);
    wr(OFF_PBT, 32'h00000405);
    // main clock stays the base source until the lock wait is over
    wr(OFF_CDIV, 32'h0000009E);
    rchk(OFF_CDIV, 32'h0000009E);
    wr(OFF_PROTECT, 32'h00000004);
    wr(OFF_PLL_REF, 32'h00000001);
    wr(OFF_PLL_FB, 32'h00000004);
    rchk(OFF_PLL_FB, 32'h00000000);
    wr(OFF_PROTECT, 32'h00000004);
    wr(OFF_PLL_FB, 32'h00000004);
    rchk(OFF_PLL_REF, 32'h00000001);
    rchk(OFF_PLL_FB, 32'h00000004);
    wr(OFF_PROTECT, 32'h00000001);
    wr(OFF_PMODE, 32'h00000040);
    rchk(OFF_PMODE, 32'h00000040);
    $display("test guard done");
  endtask

  task automatic t_pll;
    int n;
    n = 0;
    wr(OFF_CTRL, 32'h00023E80);
    chk({31'h0, pll_locked}, 32'h00000000);
    while (pll_locked !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    chk_rate(n, LOCK_SIM, 1);
    wr(OFF_CDIV, 32'h0000001F);
    repeat (300) @(posedge ref_clk);
    count(400);
    chk_rate(tc[0], 200, 2);
    chk_rate(tc[1], 100, 2);
    chk_rate(tc[2], 100, 2);
    chk_rate(tc[3], 50, 2);
    chk_rate(tc[4], 50, 2);
    $display("test pll done");
  endtask

  task automatic t_timer;
    int t0;
    wr(OFF_CTRL, 32'h00030004);
    t0 = cyc;
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({31'h0, rd[3]}, 32'h00000001);
    while (rd[2] !== 1'b1 && cyc - t0 < 400) apb(1'b0, OFF_STATUS, 32'h0);
    chk_rate(cyc - t0, 100, 30);
    $display("test timer done");
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_guard();
    t_pll();
    t_timer();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
